// >>> hw/rsadu_fifo.sv
`timescale 1ns/1ps
module rsadu_fifo
  import rsadu_pkg::*;
(
  // Clock and reset.
  input wire logic mclk_i,
  input wire logic reset_i,
  // Filling side.
  input wire logic in_valid_i,
  input wire logic [7:0] in_data_i,
  output logic in_ready_o,
  // Draining side.
  output logic out_valid_o,
  output logic [7:0] out_data_o,
  input wire logic out_ready_i
);

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  // Storage, pointers, fill count and the registered output word.
  typedef struct packed {
    logic [FIFO_DEPTH-1:0][7:0] mem;
    logic [3:0] wp;
    logic [3:0] rp;
    logic [4:0] cnt;
    logic ov;
    logic [7:0] dout;
  } rsadu_fifo_s;

  rsadu_fifo_s r;
  rsadu_fifo_s next_r;

  assign in_ready_o = (r.cnt != FIFO_FULL);
  assign out_valid_o = r.ov;
  assign out_data_o = r.dout;

  // Move a word to the output register whenever it is free or being taken.
  always_comb begin
    logic push;
    logic pop;
    push = 1'b0;
    pop = 1'b0;
    next_r = r;
    pop = (r.cnt != 5'h00) && (!r.ov || out_ready_i);
    push = in_valid_i && in_ready_o;
    if (pop) begin
      next_r.dout = r.mem[r.rp];
      next_r.ov = 1'b1;
      next_r.rp = r.rp + 4'h1;
    end else if (out_ready_i) begin
      next_r.ov = 1'b0;
    end
    if (push) begin
      next_r.mem[r.wp] = in_data_i;
      next_r.wp = r.wp + 4'h1;
    end
    next_r.cnt = r.cnt + {4'h0, push} - {4'h0, pop};
  end

  // Register the whole state.
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  fifo_no_overflow_a: assert property ( // R5
    @(posedge mclk_i) disable iff (reset_i) r.cnt <= FIFO_FULL)
    else $error("fifo count above depth");

endmodule // rsadu_fifo

// >>> hw/rsadu_pkg.sv
package rsadu_pkg;

  // ----------------------------------------------------------------------
  // Clocking and reference generation
  // ----------------------------------------------------------------------
  // System clock rate in hertz.
  localparam longint MCLK_HZ = 64'd250_000_000;
  // Standard and fourfold UART reference clock rates in hertz.
  localparam longint REF_STD_HZ = 64'd1_843_200;
  localparam longint REF_FAST_HZ = 64'd7_372_800;
  // Highest supported baud rates in each reference range.
  localparam longint MAX_BAUD_STD = 64'd115_200;
  localparam longint MAX_BAUD_FAST = 64'd460_800;
  // Phase accumulator width and the per-cycle increments for each range.
  localparam int ACC_W = 24;
  localparam logic [23:0] ACC_INC_STD = 24'((REF_STD_HZ << ACC_W) / MCLK_HZ);
  localparam logic [23:0] ACC_INC_FAST = 24'((REF_FAST_HZ << ACC_W) / MCLK_HZ);

  // ----------------------------------------------------------------------
  // Buffers
  // ----------------------------------------------------------------------
  // Each direction stores sixteen bytes, plus one more in the buffer's output register.
  localparam int FIFO_DEPTH = 16;
  localparam logic [4:0] FIFO_FULL = 5'h10;

  // ----------------------------------------------------------------------
  // Character framing
  // ----------------------------------------------------------------------
  // Sixteen baud ticks per bit; the start bit is checked at mid-bit.
  localparam logic [5:0] OVS_LAST = 6'h0f;
  localparam logic [5:0] HALF_LAST = 6'h07;
  localparam logic [5:0] BIT_TICKS = 6'h10;
  localparam logic [5:0] STOP_1 = 6'h10;
  localparam logic [5:0] STOP_15 = 6'h18;
  localparam logic [5:0] STOP_2 = 6'h20;
  // Index of the last data bit for the shortest (five bit) word.
  localparam logic [2:0] WORD_MIN_LAST = 3'h4;
  // Line control field positions, laid out as in the classic port.
  localparam int LCR_WLS = 0;
  localparam int LCR_STB = 2;
  localparam int LCR_PEN = 3;
  localparam int LCR_EPS = 4;

  // ----------------------------------------------------------------------
  // State machines
  // ----------------------------------------------------------------------
  typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP} rsadu_tx_e;
  typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP} rsadu_rx_e;

  // Length of the stop interval in ticks; 1.5 bits only for five-bit words.
  function automatic logic [5:0] stop_ticks(input logic [4:0] lcr);
    if (!lcr[LCR_STB]) begin
      return STOP_1;
    end
    return (lcr[LCR_WLS+:2] == 2'h0) ? STOP_15 : STOP_2;
  endfunction

  // Whole character time in ticks: start, data, parity and stop.
  function automatic logic [8:0] char_ticks(input logic [4:0] lcr);
    logic [3:0] nbits;
    nbits = 4'h1 + 4'h5 + {2'h0, lcr[LCR_WLS+:2]} + {3'h0, lcr[LCR_PEN]};
    return {1'b0, nbits, 4'h0} + {3'h0, stop_ticks(lcr)};
  endfunction

endpackage

// >>> hw/rsadu_uart.sv
//Contract
//R1: Driver enabled as soon as data pending.
//R2: Driver held one extra character time.
//R3: Receiver on, except while driver enabled; the code gates it off only in RS485 mode and keeps it on in RS422.
//R4: Hold-over follows the programmed character framing.
//R5: Sixteen byte transmit and receive buffers.
//R6: Line control laid out like classic port.
//R7: Standard reference supports up to 115200 baud.
//R8: Fast reference supports up to 460800 baud.
//R9: Host programs divisor; hardware applies it.
//R10: Half duplex never transmits and receives together.
//R11: Reference is 1.8432 or 7.3728 MHz.
//R12: Strap selects RS422 or RS485 line mode.
//R13: Five to eight bits, parity, stops.
//R14: Hold-over starts when buffer and shifter empty.
`timescale 1ns/1ps
module rsadu_uart
  import rsadu_pkg::*;
(
  // Clock and reset.
  input wire logic mclk_i,
  input wire logic reset_i,
  // Transmit byte stream from the host.
  input wire logic tx_valid_i,
  input wire logic [7:0] tx_data_i,
  output logic tx_ready_o,
  // Receive byte stream to the host.
  output logic rx_valid_o,
  output logic [7:0] rx_data_o,
  input wire logic rx_ready_i,
  // Configuration from host software.
  input wire logic [15:0] divisor_i,
  input wire logic [4:0] line_ctrl_i,
  // Board straps.
  input wire logic ref_clock_range_select_i,
  input wire logic mode_rs485_i,
  // Line transceiver.
  output logic txd_o,
  input wire logic rxd_i,
  output logic drv_en_o,
  output logic rcv_en_o,
  // Receive status pulses.
  output logic parity_err_o,
  output logic frame_err_o,
  output logic overrun_o
);

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic rng_s1;          // Range strap, first sync stage.
    logic rng_s2;          // Range strap, synchronised.
    logic mode_s1;         // Line mode strap, first sync stage.
    logic mode_s2;         // Line mode strap, synchronised.
    logic [23:0] acc;      // Reference phase accumulator.
    logic [15:0] dcnt;     // Divisor countdown.
    logic tick;            // Sixteen-times-baud pulse.
    rsadu_tx_e tx_st;      // Transmit sequencer.
    logic [5:0] tx_tk;     // Ticks within the current transmit bit.
    logic [2:0] tx_bit;    // Transmit data bit index.
    logic [7:0] tx_sh;     // Transmit shifter.
    logic tx_par;          // Running transmit parity.
    logic txd;             // Registered line output.
    logic [8:0] hold;      // Driver hold-over ticks remaining.
    logic rx_s1;           // Line input, first sync stage.
    logic rx_s2;           // Line input, synchronised.
    logic rx_s3;           // Delayed copy for edge detection.
    rsadu_rx_e rx_st;      // Receive sequencer.
    logic [5:0] rx_tk;     // Ticks within the current receive bit.
    logic [2:0] rx_bit;    // Receive data bit index.
    logic [7:0] rx_sh;     // Receive shifter.
    logic rx_par;          // Running receive parity.
    logic rx_push;         // One-cycle push into the receive buffer.
    logic [7:0] rx_data;   // Word being pushed.
    logic perr;            // Parity error pulse.
    logic ferr;            // Framing error pulse.
    logic ovr;             // Overrun pulse.
  } rsadu_uart_s;

  rsadu_uart_s r;
  rsadu_uart_s next_r;

  // Buffer handshakes.
  logic tx_ov;
  logic [7:0] tx_od;
  logic tx_take;
  logic rx_in_ready;
  logic rxv;

  // ----------------------------------------------------------------------
  // Buffers
  // ----------------------------------------------------------------------
  // Each direction has its own buffer; a received word that finds its buffer full is dropped.
  // R5: buffer instances
  rsadu_fifo u_tx_fifo (
    .mclk_i(mclk_i),
    .reset_i(reset_i),
    .in_valid_i(tx_valid_i),
    .in_data_i(tx_data_i),
    .in_ready_o(tx_ready_o),
    .out_valid_o(tx_ov),
    .out_data_o(tx_od),
    .out_ready_i(tx_take)
  );

  rsadu_fifo u_rx_fifo (
    .mclk_i(mclk_i),
    .reset_i(reset_i),
    .in_valid_i(r.rx_push),
    .in_data_i(r.rx_data),
    .in_ready_o(rx_in_ready),
    .out_valid_o(rx_valid_o),
    .out_data_o(rx_data_o),
    .out_ready_i(rx_ready_i)
  );

  // The shifter takes a word only while idle.
  assign tx_take = (r.tx_st == TX_IDLE) && tx_ov;

  // Direction control is decoded from registered state only.
  // R1: pending data drives
  assign drv_en_o = (r.tx_st != TX_IDLE) || tx_ov || (r.hold != 9'h000);
  // R3: receiver gated off
  // R12: RS422 keeps receiver
  assign rcv_en_o = !r.mode_s2 || !drv_en_o;
  // A gated receiver sees an idle line, so it cannot start a frame.
  assign rxv = rcv_en_o ? r.rx_s2 : 1'b1;

  assign txd_o = r.txd;
  assign parity_err_o = r.perr;
  assign frame_err_o = r.ferr;
  assign overrun_o = r.ovr;

  // ----------------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------------
  always_comb begin
    logic ref_tick;
    logic [24:0] sum;
    logic [2:0] last;
    ref_tick = 1'b0;
    sum = 25'h0;
    last = WORD_MIN_LAST + {1'b0, line_ctrl_i[LCR_WLS+:2]};
    next_r = r;
    next_r.rng_s1 = ref_clock_range_select_i;
    next_r.rng_s2 = r.rng_s1;
    next_r.mode_s1 = mode_rs485_i;
    next_r.mode_s2 = r.mode_s1;
    next_r.rx_s1 = rxd_i;
    next_r.rx_s2 = r.rx_s1;
    next_r.rx_s3 = r.rx_s2;
    next_r.rx_push = 1'b0;
    next_r.perr = 1'b0;
    next_r.ferr = 1'b0;
    next_r.ovr = 1'b0;

    // The accumulator stands in for the oscillator; its carry is a reference edge.
    // R11: reference rate select
    // R8: fourfold range
    sum = {1'b0, r.acc} + {1'b0, (r.rng_s2 ? ACC_INC_FAST : ACC_INC_STD)};
    next_r.acc = sum[23:0];
    ref_tick = sum[24];

    // A divisor of zero behaves as one rather than stopping the port.
    // R9: divisor applied
    // R7: standard range
    next_r.tick = 1'b0;
    if (ref_tick) begin
      if (r.dcnt <= 16'h0001) begin
        next_r.dcnt = divisor_i;
        next_r.tick = 1'b1;
      end else begin
        next_r.dcnt = r.dcnt - 16'h0001;
      end
    end

    // Transmit sequencer.
    // R13: framing options
    // R6: classic control layout
    case (r.tx_st)
      TX_IDLE: begin
        if (tx_take) begin
          next_r.tx_sh = tx_od;
          next_r.tx_st = TX_START;
          next_r.tx_tk = 6'h00;
          next_r.tx_par = !line_ctrl_i[LCR_EPS];
          next_r.hold = 9'h000;
        end
      end
      TX_START: begin
        if (r.tick) begin
          next_r.tx_tk = r.tx_tk + 6'h01;
          if (r.tx_tk == OVS_LAST) begin
            next_r.tx_tk = 6'h00;
            next_r.tx_bit = 3'h0;
            next_r.tx_st = TX_DATA;
          end
        end
      end
      TX_DATA: begin
        if (r.tick) begin
          next_r.tx_tk = r.tx_tk + 6'h01;
          if (r.tx_tk == OVS_LAST) begin
            next_r.tx_tk = 6'h00;
            next_r.tx_par = r.tx_par ^ r.tx_sh[0];
            next_r.tx_sh = {1'b0, r.tx_sh[7:1]};
            next_r.tx_bit = r.tx_bit + 3'h1;
            if (r.tx_bit == last) begin
              next_r.tx_st = line_ctrl_i[LCR_PEN] ? TX_PAR : TX_STOP;
            end
          end
        end
      end
      TX_PAR: begin
        if (r.tick) begin
          next_r.tx_tk = r.tx_tk + 6'h01;
          if (r.tx_tk == OVS_LAST) begin
            next_r.tx_tk = 6'h00;
            next_r.tx_st = TX_STOP;
          end
        end
      end
      TX_STOP: begin
        if (r.tick) begin
          next_r.tx_tk = r.tx_tk + 6'h01;
          if (r.tx_tk == stop_ticks(line_ctrl_i) - 6'h01) begin
            next_r.tx_st = TX_IDLE;
            // R14: empty starts hold
            // R4: rate-scaled hold
            if (!tx_ov) begin
              next_r.hold = char_ticks(line_ctrl_i);
            end
          end
        end
      end
      default: begin
        next_r.tx_st = TX_IDLE;
      end
    endcase

    // Hold-over counts in baud ticks, so it tracks every divisor.
    // R2: extra character time
    if (r.tick && (r.hold != 9'h000) && (next_r.hold == r.hold)) begin
      next_r.hold = r.hold - 9'h001;
    end

    case (next_r.tx_st)
      TX_START: next_r.txd = 1'b0;
      TX_DATA: next_r.txd = next_r.tx_sh[0];
      TX_PAR: next_r.txd = next_r.tx_par;
      default: next_r.txd = 1'b1;
    endcase

    // Receive sequencer; samples are taken at mid-bit.
    case (r.rx_st)
      RX_IDLE: begin
        if (r.rx_s3 && !rxv) begin
          next_r.rx_st = RX_START;
          next_r.rx_tk = 6'h00;
        end
      end
      RX_START: begin
        if (r.tick) begin
          next_r.rx_tk = r.rx_tk + 6'h01;
          if (r.rx_tk == HALF_LAST) begin
            // A start bit that is gone by mid-bit was a glitch.
            next_r.rx_st = rxv ? RX_IDLE : RX_DATA;
            next_r.rx_tk = 6'h00;
            next_r.rx_bit = 3'h0;
            next_r.rx_par = !line_ctrl_i[LCR_EPS];
          end
        end
      end
      RX_DATA: begin
        if (r.tick) begin
          next_r.rx_tk = r.rx_tk + 6'h01;
          if (r.rx_tk == OVS_LAST) begin
            next_r.rx_tk = 6'h00;
            next_r.rx_sh = {rxv, r.rx_sh[7:1]};
            next_r.rx_par = r.rx_par ^ rxv;
            next_r.rx_bit = r.rx_bit + 3'h1;
            if (r.rx_bit == last) begin
              next_r.rx_st = line_ctrl_i[LCR_PEN] ? RX_PAR : RX_STOP;
            end
          end
        end
      end
      RX_PAR: begin
        if (r.tick) begin
          next_r.rx_tk = r.rx_tk + 6'h01;
          if (r.rx_tk == OVS_LAST) begin
            next_r.rx_tk = 6'h00;
            next_r.perr = rxv ^ r.rx_par;
            next_r.rx_st = RX_STOP;
          end
        end
      end
      RX_STOP: begin
        if (r.tick) begin
          next_r.rx_tk = r.rx_tk + 6'h01;
          if (r.rx_tk == OVS_LAST) begin
            next_r.rx_st = RX_IDLE;
            next_r.ferr = !rxv;
            next_r.rx_push = 1'b1;
            next_r.rx_data = r.rx_sh >> (2'h3 - line_ctrl_i[LCR_WLS+:2]);
          end
        end
      end
      default: begin
        next_r.rx_st = RX_IDLE;
      end
    endcase

    // R10: half duplex exclusion
    if (!rcv_en_o) begin
      next_r.rx_st = RX_IDLE;
    end

    // A word pushed into a full buffer is dropped and flagged.
    next_r.ovr = r.rx_push && !rx_in_ready;
  end

  // Register the whole state; the line rests high out of reset.
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      r <= '0;
      r.txd <= 1'b1;
      r.rx_s1 <= 1'b1;
      r.rx_s2 <= 1'b1;
      r.rx_s3 <= 1'b1;
    end else begin
      r <= next_r;
    end
  end

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (reset_i);

  pending_drives_a: assert property ((tx_valid_i && tx_ready_o) |=> ##1 drv_en_o) // R1
    else $error("data pending without driver");
  hold_keeps_a: assert property ( // R2
    ($fell(drv_en_o) && !$past(reset_i)) |-> ($past(r.hold) == 9'h001))
    else $error("driver dropped before hold ended");
  hold_load_a: assert property ( // R14
    (r.tick && r.tx_st == TX_STOP && next_r.tx_st == TX_IDLE && !tx_ov)
    |=> (r.hold == char_ticks(line_ctrl_i)))
    else $error("hold not loaded at end of stop");
  hold_count_a: assert property ( // R4
    (r.tick && r.tx_st == TX_IDLE && r.hold != 9'h000 && !tx_ov)
    |=> (r.hold == $past(r.hold) - 9'h001))
    else $error("hold does not count baud ticks");
  rcv_gated_a: assert property ((r.mode_s2 && drv_en_o) |-> !rcv_en_o) // R3
    else $error("receiver on while driving");
  rcv_default_a: assert property (!drv_en_o |-> rcv_en_o) // R3
    else $error("receiver off while idle");
  half_duplex_a: assert property ((r.mode_s2 && drv_en_o) |=> (r.rx_st == RX_IDLE)) // R10
    else $error("receiving while transmitting");
  tick_space_a: assert property (r.tick |=> !r.tick [*8]) // R9
    else $error("baud ticks too close");
  stop_high_a: assert property ((r.tx_st == TX_STOP) |=> txd_o) // R13
    else $error("stop bit not high");

  frame_sent_c: cover property (r.tx_st == TX_STOP ##1 r.tx_st == TX_IDLE);
  word_rcvd_c: cover property (r.rx_push && rx_in_ready);
  hold_done_c: cover property (r.hold == 9'h001 ##1 !drv_en_o);

endmodule // rsadu_uart

// >>> verification/rs485_auto_direction_uart_test.sv
`timescale 1ns/1ps
module rs485_auto_direction_uart_test;
  import rsadu_pkg::*;
  // --------------------------------------------------------------------------
  // Signals
  // --------------------------------------------------------------------------
  logic mclk_i = 1'b0;
  logic reset_i = 1'b1;
  logic tx_valid_i = 1'b0;
  logic [7:0] tx_data_i = 8'h00;
  logic tx_ready_o, rx_valid_o, rx_ready_i = 1'b0;
  logic [7:0] rx_data_o;
  logic [15:0] divisor_i = 16'h0001;
  logic [4:0] line_ctrl_i = 5'h03;
  logic ref_clock_range_select_i = 1'b1;
  logic mode_rs485_i = 1'b1;
  logic txd_o, rxd_i, drv_en_o, rcv_en_o, parity_err_o, frame_err_o, overrun_o;
  int fail_count = 0;
  int total_checks = 0;
  int err_cnt = 0;
  logic [7:0] got_rx;

  // A 4 ns clock period gives the 250 MHz system clock.
  always #2 mclk_i = ~mclk_i;

  rsadu_uart u_dut (.mclk_i(mclk_i), .reset_i(reset_i), .tx_valid_i(tx_valid_i),
    .tx_data_i(tx_data_i), .tx_ready_o(tx_ready_o), .rx_valid_o(rx_valid_o),
    .rx_data_o(rx_data_o), .rx_ready_i(rx_ready_i), .divisor_i(divisor_i),
    .line_ctrl_i(line_ctrl_i), .ref_clock_range_select_i(ref_clock_range_select_i),
    .mode_rs485_i(mode_rs485_i), .txd_o(txd_o), .rxd_i(rxd_i), .drv_en_o(drv_en_o),
    .rcv_en_o(rcv_en_o), .parity_err_o(parity_err_o), .frame_err_o(frame_err_o),
    .overrun_o(overrun_o));
  rsadu_remote_node u_node (.line_i(txd_o), .line_o(rxd_i));

  // Receive error pulses last one cycle, so every falling edge looks at them.
  always @(negedge mclk_i) begin
    if (parity_err_o !== 1'b0 || frame_err_o !== 1'b0 || overrun_o !== 1'b0) begin
      err_cnt++;
    end
  end

  // --------------------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------------------
  task automatic conclude;
    if (fail_count == 0 && total_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // Exact compare; the tolerant form below absorbs reference-tick jitter.
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    check_near(got, exp, 16'h0000);
  endtask

  task automatic check_near(input logic [15:0] got, input logic [15:0] exp,
                            input logic [15:0] tol);
    total_checks++;
    if (got === 16'hxxxx || got > exp + tol || got + tol < exp || (^got) === 1'bx) begin
      fail_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Configuration only changes while the line is idle.
  task automatic configure(input logic [4:0] lcr, input logic [15:0] dv, input logic rng,
                           input logic m485);
    @(negedge mclk_i);
    line_ctrl_i = lcr;
    divisor_i = dv;
    ref_clock_range_select_i = rng;
    mode_rs485_i = m485;
    repeat (4) @(negedge mclk_i);
  endtask

  // Offers one byte and holds it until the edge that takes it.
  task automatic push(input logic [7:0] d);
    int n;
    @(negedge mclk_i);
    tx_valid_i = 1'b1;
    tx_data_i = d;
    n = 0;
    while (tx_ready_o !== 1'b1) begin
      n++;
      if (n > 100) begin
        fail_count++;
        conclude();
      end
      @(negedge mclk_i);
    end
    @(posedge mclk_i);
    @(negedge mclk_i);
    tx_valid_i = 1'b0;
  endtask

  // Sends a byte and times the driver window against the framing.
  task automatic drive_and_watch(input logic [7:0] d, input logic m485, input int exp);
    int n;
    int h;
    int rbad;
    push(d);
    n = 2;
    while (drv_en_o !== 1'b1 && n < 10) begin
      @(negedge mclk_i);
      n++;
    end
    // The driver must come on within a few cycles of the take.
    check_near(16'(n), 16'h0003, 16'h0001);
    h = 0;
    rbad = 0;
    while (drv_en_o === 1'b1 && h < 60000) begin
      if (rcv_en_o !== !m485) rbad++;
      @(negedge mclk_i);
      h++;
    end
    // The window covers the frame plus one more character time.
    check_near(16'(h), 16'(exp), 16'(exp / 50 + 8));
    check(16'(rbad), 16'h0000);
    check({15'h0, rcv_en_o}, 16'h0001);
    // A wait that ran out has already counted a mismatch; stop here.
    if (n >= 10 || h >= 60000) conclude();
  endtask

  // Runs one transmit case; the remote node decodes what reached the line.
  task automatic tx_case(input logic [7:0] d, input int nb, input logic pen,
                         input logic [4:0] lcr, input logic [15:0] dv, input logic rng,
                         input logic m485);
    real tick;
    real bit_ns;
    int ct;
    logic [7:0] got;
    tick = 16777216.0 / real'(rng ? ACC_INC_FAST : ACC_INC_STD);
    bit_ns = 16.0 * dv * tick * 4.0;
    ct = 16 * (1 + nb + pen) + (lcr[2] ? ((nb == 5) ? 24 : 32) : 16);
    configure(lcr, dv, rng, m485);
    fork
      u_node.capture(nb, bit_ns, got);
      drive_and_watch(d, m485, int'(2.0 * ct * dv * tick));
    join
    check({8'h00, got}, {8'h00, d & ((8'h01 << nb) - 8'h01)});
    // An unknown word means the node never saw a start bit.
    if ((^got) === 1'bx) conclude();
  endtask

  // --------------------------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------------------------
  initial begin
    int acc;
    int n;
    repeat (4) @(negedge mclk_i);
    reset_i = 1'b0;
    @(negedge mclk_i);
    check({11'h0, txd_o, drv_en_o, rcv_en_o, tx_ready_o, rx_valid_o}, 16'h0016);
    tx_case(8'ha5, 8, 1'b0, 5'h03, 16'h0001, 1'b1, 1'b1);
    tx_case(8'h5a, 7, 1'b1, 5'h1e, 16'h0002, 1'b1, 1'b1);
    tx_case(8'h35, 5, 1'b0, 5'h00, 16'h0001, 1'b0, 1'b1);
    // Both directions at once with the receiver left on, as in four-wire use.
    fork
      begin
        #(400);
        u_node.send_frame(8'h3c, 8, 1'b0, 1'b0, 2, 64.0 * 16777216.0 / ACC_INC_FAST);
      end
      tx_case(8'hc3, 8, 1'b0, 5'h03, 16'h0001, 1'b1, 1'b0);
    join
    n = 0;
    while (rx_valid_o !== 1'b1 && n < 2000) begin
      @(negedge mclk_i);
      n++;
    end
    check({8'h00, rx_data_o}, 16'h003c);
    if (n >= 2000) conclude();
    rx_ready_i = 1'b1;
    @(negedge mclk_i);
    rx_ready_i = 1'b0;
    check(16'(err_cnt), 16'h0000);
    // A parity bit of the wrong sense still delivers the word and one error pulse.
    configure(5'h1b, 16'h0001, 1'b1, 1'b1);
    u_node.send_frame(8'h96, 8, 1'b1, 1'b0, 2, 64.0 * 16777216.0 / ACC_INC_FAST);
    n = 0;
    while (rx_valid_o !== 1'b1 && n < 2000) begin
      @(negedge mclk_i);
      n++;
    end
    check({8'h00, rx_data_o}, 16'h0096);
    check(16'(err_cnt), 16'h0001);
    if (n >= 2000) conclude();
    rx_ready_i = 1'b1;
    @(negedge mclk_i);
    rx_ready_i = 1'b0;
    // Fill the transmit buffer until it refuses; the shifter drains slowly.
    tx_valid_i = 1'b1;
    tx_data_i = 8'h11;
    acc = 0;
    repeat (40) begin
      if (tx_ready_o === 1'b1) acc++;
      @(negedge mclk_i);
    end
    check_near(16'(acc), 16'h0011, 16'h0001);
    check({15'h0, tx_ready_o}, 16'h0000);
    // A reset in mid-frame must drop the driver and free the buffer.
    tx_valid_i = 1'b0;
    reset_i = 1'b1;
    repeat (2) @(negedge mclk_i);
    reset_i = 1'b0;
    check({12'h0, txd_o, drv_en_o, rcv_en_o, tx_ready_o}, 16'h000b);
    // One edge after release the port must still rest idle.
    @(negedge mclk_i);
    check({12'h0, txd_o, drv_en_o, rcv_en_o, tx_ready_o}, 16'h000b);
    conclude();
  end
endmodule // rs485_auto_direction_uart_test

// >>> verification/rsadu_remote_node.sv
`timescale 1ns/1ps
// --------------------------------------------------------------------------
// Remote serial node on the far end of the differential pair
// --------------------------------------------------------------------------
module rsadu_remote_node (
  // Line driven by the device.
  input wire logic line_i,
  // Line driven towards the device.
  output logic line_o
);
  // The biased pair rests at mark, so an idle line reads high.
  initial begin
    line_o = 1'b1;
  end

  // Sends one frame; the caller picks the bit time to match the device.
  // word framing
  task automatic send_frame(input logic [7:0] d, input int nb, input logic pen,
                            input logic even, input int halves, input real bit_ns);
    int i;
    line_o = 1'b0;
    #(bit_ns);
    for (i = 0; i < nb; i++) begin
      line_o = d[i];
      #(bit_ns);
    end
    // The parity bit covers only the bits that were sent.
    if (pen) begin
      line_o = (^(d & ((8'h01 << nb) - 8'h01))) ^ ~even;
      #(bit_ns);
    end
    line_o = 1'b1;
    #(bit_ns * halves / 2.0);
  endtask

  // Waits a bounded time for a start bit, then samples each bit at mid-bit.
  // word framing
  task automatic capture(input int nb, input real bit_ns, output logic [7:0] d);
    int t;
    int i;
    d = 8'h00;
    t = 0;
    while (line_i !== 1'b0 && t < 4000) begin
      #(bit_ns / 16.0);
      t++;
    end
    // A missing frame yields an unknown word, so the caller cannot match it.
    if (t == 4000) begin
      d = 8'hxx;
    end else begin
      #(bit_ns * 1.5);
      for (i = 0; i < nb; i++) begin
        d[i] = line_i;
        #(bit_ns);
      end
    end
  endtask
endmodule // rsadu_remote_node
